/* rtl/omf_mode_fsm.sv */
// Operating-mode state machine: power-up, reset pin, fault, sleep and polling
`timescale 1ns/10ps
// Notes on behaviour
// - Reset-pin rise enters init for blanking time, then fault or normal.
// - Commands are processed only once normal has been reached.
// - Off moves to nonvolatile load on a power-on-reset rising edge.
// - Load ends in wake when memory is ready with good trim and calibration data, good diagnostics and no supply fault; bad data sets trim fault.
// - With load faults, wake is still reached when the load timeout expires.
// - Wake entry raises wake pin and flag; a status read clears both.
// - Wake to init on reset rise, latching the chip address pin.
// - Init goes normal when diagnostics stayed good for the blanking time and no supply or unmasked overtemperature fault is present.
// - Init goes fault when diagnostics stayed bad for the blanking time.
// - Normal goes fault on unmasked overtemperature or internal supply fault.
// - In fault, internal reference stays on; command interface stays on only if normal was reached after the last init.
// - Fault returns to normal once its cause has gone.
// - Three activation writes then reset low in normal enter sleep, keeping settings.
// - Sleep moves to polling whenever the polling timeout expires.
// - Polling returns to sleep if wake sources stay still for blanking time.
// - Polling goes to wake if a source change lasts blanking plus polling.
// - Any reset-low state goes to init on a reset-pin rise.
// - Reset low in normal, fault or init holds reset and drops settings.
// - Reset pin deglitched: 16 us in sleep and polling, 1 us otherwise.
// - Battery below power-on-reset level forces off from any state.
// - Blanking 160 us and polling 16 ms by default, two-bit programmable.
// - Entering power-on reset or held reset restores default timeouts.
// - In normal operation timing runs from the main oscillator.
// - In sleep timing runs from the low-power oscillator.
module omf_mode_fsm #(
  parameter int P_POLL_US = omf_pkg::PT_DEF_US, // Default polling timeout, us
  parameter int P_NVM_US  = omf_pkg::NVM_TO_US  // Nonvolatile load timeout, us
) (
  input  wire logic                       i_sys_clk,          // System clock, 10 MHz
  input  wire logic                       i_resetn,           // Async reset, low active
  input  wire logic                       i_por_ok,           // Battery above POR level
  input  wire logic                       i_rst_pin,          // Reset pin from host
  input  wire logic                       i_ctrl_cfg_pin,     // Chip address select pin
  input  wire logic [omf_pkg::WK_N-1:0]   i_wake_src,         // Wake-up source levels
  input  wire logic                       i_nvm_ready,        // Nonvolatile memory ready
  input  wire logic                       i_nvm_data_bad,     // Loaded trim data invalid
  input  wire logic                       i_calib_bad,        // Loaded calibration invalid
  input  wire logic                       i_diag_ok,          // Diagnostic check good
  input  wire logic                       i_int_supply_fault, // Internal supply fault
  input  wire logic                       i_overtemp,         // Overtemperature seen
  input  wire logic                       i_ot_mask,          // Overtemperature masked
  input  wire logic                       i_cfg_wr,           // Config register write
  input  wire omf_pkg::omf_cfg_wr_t       i_cfg_wdata,        // Config write data
  input  wire logic                       i_status_rd,        // Status register read
  output omf_pkg::omf_state_t             o_state,            // Present mode
  output logic                            o_wake_pin,         // Wake output pin
  output omf_pkg::omf_status_t            o_status,           // Status flags
  output omf_pkg::omf_timeout_cfg_t       o_timeout_cfg,      // Timeout codes
  output logic                            o_spi_enable,       // Command processing on
  output logic                            o_vref_en,          // Internal reference on
  output logic                            o_lp_osc_sel,       // Low-power timebase
  output logic                            o_chip_addr         // Latched chip address
);
  import omf_pkg::*;

  typedef struct packed {
    omf_state_t       st;
    logic             rst_prev;
    logic             por_prev;
    logic             diag_prev;
    logic [WK_N-1:0]  wk_ref;
    omf_status_t      stat;
    omf_timeout_cfg_t tcfg;
    logic [1:0]       act_cnt;
    logic             normal_seen;
    logic             spi_en;
    logic             vref_en;
    logic             lp_osc;
    logic             chip_addr;
  } omf_core_t;

  localparam omf_core_t CORE_RST = '{
    st:        ST_OFF,
    tcfg:      '{polling_timeout: PT_CODE_DEF, blanking_timeout: PB_CODE_DEF},
    chip_addr: ADDR_DEF,
    default:   '0
  };

  omf_core_t       r;
  omf_core_t       r_nxt;
  logic            rst_q;
  logic            por_q;
  logic            cfg_q;
  logic [WK_N-1:0] wk_q;
  logic [FW-1:0]   rst_len;
  logic [TW-1:0]   t_us;
  logic [TW-1:0]   c_us;
  logic [TW-1:0]   pb_us;
  logic [TW-1:0]   pt_us;
  logic            t_clr;
  logic            c_clr;
  logic            rst_rise;
  logic            rst_fall;
  logic            ot_evt;
  logic            fault_now;
  logic            wk_chg;
  logic            discard;

  function automatic logic [TW-1:0] pb_lut(input logic [1:0] code);
    logic [TW-1:0] v;
    unique case (code)
      2'h0: v = TW'(PB_C0_US);
      2'h1: v = TW'(PB_C1_US);
      2'h2: v = TW'(PB_C2_US);
      2'h3: v = TW'(PB_C3_US);
    endcase
    return v;
  endfunction

  function automatic logic [TW-1:0] pt_lut(input logic [1:0] code);
    logic [TW-1:0] v;
    unique case (code)
      2'h0: v = TW'(P_POLL_US);
      2'h1: v = TW'(P_POLL_US * 2);
      2'h2: v = TW'(P_POLL_US / 2);
      2'h3: v = TW'(P_POLL_US * 4);
    endcase
    return v;
  endfunction

  // Longer filter while the slow timebase runs
  assign rst_len = r.lp_osc ? FW'(RST_FLT_SLP_CYC) : FW'(RST_FLT_NRM_CYC);

  omf_pin_filter #(
    .W (1)
  ) u_rst_flt (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_pin     (i_rst_pin),
    .i_len     (rst_len),
    .o_level   (rst_q)
  );

  omf_pin_filter #(
    .W (WK_N + 2)
  ) u_pin_sync (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_pin     ({i_por_ok, i_ctrl_cfg_pin, i_wake_src}),
    .i_len     ('0),
    .o_level   ({por_q, cfg_q, wk_q})
  );

  // State timer, restarted on each mode change
  omf_timer u_state_tmr (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_clear   (t_clr),
    .o_us      (t_us)
  );

  // Persistence timer for a wake-source change while polling
  omf_timer u_wake_tmr (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_clear   (c_clr),
    .o_us      (c_us)
  );

  assign pb_us     = pb_lut(r.tcfg.blanking_timeout);
  assign pt_us     = pt_lut(r.tcfg.polling_timeout);
  assign rst_rise  = rst_q & ~r.rst_prev;
  assign rst_fall  = ~rst_q & r.rst_prev;
  // A failed trim download stops overtemperature from causing a fault; the overtemperature flag still sets
  assign ot_evt    = i_overtemp & ~i_ot_mask & ~r.stat.trim_data_fault_flag;
  assign fault_now = ot_evt | i_int_supply_fault | ~i_diag_ok;
  assign wk_chg    = wk_q != r.wk_ref;

  always_comb
  begin
    r_nxt           = r;
    r_nxt.rst_prev  = rst_q;
    r_nxt.por_prev  = por_q;
    r_nxt.diag_prev = i_diag_ok;
    unique case (r.st)
      ST_OFF:
      begin
        if (por_q & ~r.por_prev)
          r_nxt.st = ST_NVM_LOAD;
      end
      ST_NVM_LOAD:
      begin
        if (i_nvm_ready & i_nvm_data_bad)
          r_nxt.stat.trim_data_fault_flag = 1'b1;
        if (i_nvm_ready & i_calib_bad)
          r_nxt.stat.calibration_fault_flag = 1'b1;
        if (i_nvm_ready & ~i_nvm_data_bad & ~i_calib_bad & i_diag_ok & ~i_int_supply_fault)
          r_nxt.st = ST_WAKE;
        else if (t_us >= TW'(P_NVM_US))
          r_nxt.st = ST_WAKE;
      end
      ST_INIT:
      begin
        // Diagnostic changes restart the blanking window below
        if (t_us >= pb_us)
          r_nxt.st = fault_now ? ST_FAULT : ST_NORMAL;
      end
      ST_NORMAL:
      begin
        if (ot_evt | i_int_supply_fault)
          r_nxt.st = ST_FAULT;
      end
      ST_FAULT:
      begin
        if (~fault_now)
          r_nxt.st = ST_NORMAL;
      end
      ST_SLEEP:
      begin
        if (t_us >= pt_us)
          r_nxt.st = ST_POLL;
      end
      ST_POLL:
      begin
        if (wk_chg & ({1'b0, c_us} >= ({1'b0, pb_us} + {1'b0, pt_us})))
          r_nxt.st = ST_WAKE;
        else if (~wk_chg & (t_us >= pb_us))
          r_nxt.st = ST_SLEEP;
      end
      ST_WAKE, ST_RST_HELD:
      begin
        r_nxt.st = r.st;
      end
    endcase

    // Writes reach the register only while commands are processed
    if (i_cfg_wr & r.spi_en)
    begin
      r_nxt.tcfg.blanking_timeout = i_cfg_wdata.blanking_timeout;
      r_nxt.tcfg.polling_timeout  = i_cfg_wdata.polling_timeout;
      if (i_cfg_wdata.key != SLEEP_KEY)
        r_nxt.act_cnt = '0;
      else if (r.act_cnt != ACT_WR_N)
        r_nxt.act_cnt = r.act_cnt + 2'h1;
    end

    // Reset pin events override the per-state decisions
    if (rst_rise & (r.st != ST_OFF))
    begin
      r_nxt.st        = ST_INIT;
      r_nxt.chip_addr = cfg_q;
    end
    else if (rst_fall)
    begin
      if ((r.st == ST_NORMAL) & (r.act_cnt == ACT_WR_N))
      begin
        r_nxt.st     = ST_SLEEP;
        r_nxt.wk_ref = wk_q;
        // The activation is spent here, so a later reset fall needs fresh writes
        r_nxt.act_cnt = '0;
      end
      else if ((r.st == ST_NORMAL) | (r.st == ST_FAULT) | (r.st == ST_INIT))
      begin
        r_nxt.st = ST_RST_HELD;
      end
    end

    if (~por_q)
      r_nxt.st = ST_OFF;

    // Held reset and power loss drop the configuration
    discard = (r_nxt.st == ST_RST_HELD) | (r_nxt.st == ST_OFF);
    if (discard)
    begin
      r_nxt.tcfg.blanking_timeout = PB_CODE_DEF;
      r_nxt.tcfg.polling_timeout  = PT_CODE_DEF;
      r_nxt.act_cnt               = '0;
    end
    if (r_nxt.st == ST_OFF)
    begin
      r_nxt.stat      = '0;
      r_nxt.chip_addr = ADDR_DEF;
    end

    // Sticky flags: a set in the cycle of a read wins over the clear; power loss clears all
    if (r_nxt.st != ST_OFF)
    begin
      r_nxt.stat.wakeup_event_flag = ((r_nxt.st == ST_WAKE) & (r.st != ST_WAKE))
                                     | (r.stat.wakeup_event_flag & ~i_status_rd);
      r_nxt.stat.overtemp_flag = i_overtemp | (r.stat.overtemp_flag & ~i_status_rd);
      r_nxt.stat.internal_supply_fault = i_int_supply_fault
                                         | (r.stat.internal_supply_fault & ~i_status_rd);
    end

    // Each pass through init must reach normal again before commands run
    r_nxt.normal_seen = (r.normal_seen | (r_nxt.st == ST_NORMAL)) & ~discard
                        & (r_nxt.st != ST_INIT);
    r_nxt.spi_en      = r_nxt.normal_seen
                        & ((r_nxt.st == ST_NORMAL) | (r_nxt.st == ST_FAULT));
    r_nxt.vref_en     = (r_nxt.st == ST_INIT) | (r_nxt.st == ST_NORMAL)
                        | (r_nxt.st == ST_FAULT);
    // Both timebases are emitted as 1 us ticks from the system clock
    r_nxt.lp_osc      = (r_nxt.st == ST_SLEEP) | (r_nxt.st == ST_POLL);
  end

  // Restart blanking whenever the diagnostic flips while in init
  assign t_clr = (r_nxt.st != r.st)
                 | ((r.st == ST_INIT) & (i_diag_ok != r.diag_prev));
  assign c_clr = ~((r.st == ST_POLL) & wk_chg);

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      r <= CORE_RST;
    else
      r <= r_nxt;
  end

  assign o_state       = r.st;
  assign o_wake_pin    = r.stat.wakeup_event_flag;
  assign o_status      = r.stat;
  assign o_timeout_cfg = r.tcfg;
  assign o_spi_enable  = r.spi_en;
  assign o_vref_en     = r.vref_en;
  assign o_lp_osc_sel  = r.lp_osc;
  assign o_chip_addr   = r.chip_addr;

endmodule

/* rtl/omf_pin_filter.sv */
// Three-stage synchroniser with a programmable stability filter
`timescale 1ns/10ps
module omf_pin_filter #(
  parameter int W = 1
) (
  input  wire logic                   i_sys_clk, // System clock
  input  wire logic                   i_resetn,  // Async reset, low active
  input  wire logic [W-1:0]           i_pin,     // Asynchronous pins
  input  wire logic [omf_pkg::FW-1:0] i_len,     // Extra stable cycles needed
  output logic      [W-1:0]           o_level    // Filtered level
);
  import omf_pkg::*;

  typedef struct packed {
    logic [W-1:0]  s1;
    logic [W-1:0]  s2;
    logic [W-1:0]  s3;
    logic [W-1:0]  lvl;
    logic [FW-1:0] cnt;
  } omf_flt_t;

  omf_flt_t r;
  omf_flt_t r_nxt;

  // Only the second stage reads the first; decisions use stages two and three
  always_comb
  begin
    r_nxt    = r;
    r_nxt.s1 = i_pin;
    r_nxt.s2 = r.s1;
    r_nxt.s3 = r.s2;
    if ((r.s2 != r.s3) || (r.s3 == r.lvl))
    begin
      r_nxt.cnt = '0;
    end
    else if (r.cnt >= i_len)
    begin
      r_nxt.lvl = r.s3;
      r_nxt.cnt = '0;
    end
    else
    begin
      r_nxt.cnt = r.cnt + FW'(1);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      r <= '0;
    else
      r <= r_nxt;
  end

  assign o_level = r.lvl;

endmodule

/* rtl/omf_pkg.sv */
// Constants and types shared by the operating-mode sequencer
package omf_pkg;

  // System clock
  localparam int CLK_MHZ         = 10;
  localparam int US_NS           = 1000;
  localparam int CYC_PER_US      = (US_NS * CLK_MHZ + 999) / 1000;

  // Reset-pin deglitch times, least times rounded up to cycles
  localparam int RST_FLT_NRM_NS  = 1000;
  localparam int RST_FLT_SLP_NS  = 16000;
  localparam int RST_FLT_NRM_CYC = (RST_FLT_NRM_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_FLT_SLP_CYC = (RST_FLT_SLP_NS * CLK_MHZ + 999) / 1000;

  // Widths
  localparam int TW              = 20;
  localparam int FW              = 8;
  localparam int PW              = 8;
  localparam int WK_N            = 3;

  // Blanking timeout per code, in microseconds
  localparam int PB_C0_US        = 160;
  localparam int PB_C1_US        = 16;
  localparam int PB_C2_US        = 40;
  localparam int PB_C3_US        = 320;

  // Polling and nonvolatile load defaults, in microseconds
  localparam int PT_DEF_US       = 16000;
  localparam int NVM_TO_US       = 3125;

  // Field codes and reset values
  localparam logic [1:0] PB_CODE_DEF = 2'h0;
  localparam logic [1:0] PT_CODE_DEF = 2'h0;
  localparam logic [3:0] SLEEP_KEY   = 4'hA;
  localparam logic [1:0] ACT_WR_N    = 2'h3;
  localparam logic       ADDR_DEF    = 1'h0;

  typedef enum logic [3:0] {
    ST_OFF,
    ST_NVM_LOAD,
    ST_WAKE,
    ST_INIT,
    ST_NORMAL,
    ST_FAULT,
    ST_SLEEP,
    ST_POLL,
    ST_RST_HELD
  } omf_state_t;

  // One write to the wake-and-sleep configuration register
  typedef struct packed {
    logic [3:0] key;
    logic [1:0] polling_timeout;
    logic [1:0] blanking_timeout;
  } omf_cfg_wr_t;

  // Timeout codes in force
  typedef struct packed {
    logic [1:0] polling_timeout;
    logic [1:0] blanking_timeout;
  } omf_timeout_cfg_t;

  // Flags of the general status register owned by this block
  typedef struct packed {
    logic wakeup_event_flag;
    logic trim_data_fault_flag;
    logic calibration_fault_flag;
    logic overtemp_flag;
    logic internal_supply_fault;
  } omf_status_t;

endpackage

/* rtl/omf_timer.sv */
// Microsecond elapsed-time counter with restart
`timescale 1ns/10ps
module omf_timer (
  input  wire logic                   i_sys_clk, // System clock
  input  wire logic                   i_resetn,  // Async reset, low active
  input  wire logic                   i_clear,   // Restart from zero
  output logic      [omf_pkg::TW-1:0] o_us       // Microseconds elapsed
);
  import omf_pkg::*;

  typedef struct packed {
    logic [PW-1:0] pre;
    logic [TW-1:0] us;
  } omf_tmr_t;

  omf_tmr_t r;
  omf_tmr_t r_nxt;

  // Saturates so a long stay never wraps back below a limit
  always_comb
  begin
    r_nxt = r;
    if (i_clear)
    begin
      r_nxt = '0;
    end
    else if (r.pre == PW'(CYC_PER_US - 1))
    begin
      r_nxt.pre = '0;
      if (r.us != '1)
        r_nxt.us = r.us + TW'(1);
    end
    else
    begin
      r_nxt.pre = r.pre + PW'(1);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      r <= '0;
    else
      r <= r_nxt;
  end

  assign o_us = r.us;

endmodule

/* test/omf_host_model.sv */
// Host controller model: reset pin and configuration writes
`timescale 1ns/10ps
module omf_host_model (
  input  wire logic            i_sys_clk,  // Clock
  output logic                 o_rst_pin,  // Reset pin
  output logic                 o_cfg_wr,   // Write strobe
  output omf_pkg::omf_cfg_wr_t o_cfg_wdata // Write data
);
  import omf_pkg::*;
  initial
  begin
    o_rst_pin = 1'b0;
    o_cfg_wr = 1'b0;
    o_cfg_wdata = 8'h00;
  end
  task automatic set_rst(input logic v, input int k);
    @(posedge i_sys_clk);
    o_rst_pin <= v;
    repeat (k) @(posedge i_sys_clk);
  endtask
  // Meant for use once commands are processed; earlier writes are dropped
  task automatic cfg_write(input logic [3:0] k, input logic [1:0] pt, input logic [1:0] pb);
    @(posedge i_sys_clk);
    o_cfg_wr <= 1'b1;
    o_cfg_wdata <= {k, pt, pb};
    @(posedge i_sys_clk);
    o_cfg_wr <= 1'b0;
    // Released data must not keep showing the last value
    o_cfg_wdata <= ~{k, pt, pb};
  endtask
  task automatic enter_sleep(input logic [1:0] pt, input logic [1:0] pb);
    repeat (3) cfg_write(SLEEP_KEY, pt, pb);
    set_rst(1'b0, 0);
  endtask
endmodule

/* test/omf_mode_fsm_monitor.sv */
// Port checks of the operating-mode sequencer
`timescale 1ns/10ps
module omf_mode_fsm_monitor
  import omf_pkg::*;
#(
  parameter int P_POLL_US = PT_DEF_US // Polling base, us
) (
  input wire logic                      i_sys_clk,          // Clock
  input wire logic                      i_resetn,           // Reset
  input wire logic                      i_por_ok,           // Battery ok
  input wire logic                      i_int_supply_fault, // Supply fault
  input wire logic                      i_cfg_wr,           // Config write
  input wire omf_pkg::omf_cfg_wr_t      i_cfg_wdata,        // Write data
  input wire omf_pkg::omf_state_t       o_state,            // Mode
  input wire logic                      o_wake_pin,         // Wake pin
  input wire omf_pkg::omf_status_t      o_status,           // Flags
  input wire omf_pkg::omf_timeout_cfg_t o_timeout_cfg,      // Codes
  input wire logic                      o_spi_enable,       // Commands on
  input wire logic                      o_vref_en           // Reference on
);
  omf_state_t  st_r;
  logic [15:0] cnt_r;
  int          pb_cyc;
  int          pt_cyc;
  // Duration of the state just left; a slack of one timer tick is allowed
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_r <= ST_OFF;
      cnt_r <= 16'h0;
    end
    else
    begin
      st_r <= o_state;
      cnt_r <= (o_state != st_r) ? 16'h1 : cnt_r + 16'h1;
    end
  end
  always_comb
  begin
    case (o_timeout_cfg.blanking_timeout)
      2'h1: pb_cyc = PB_C1_US * CYC_PER_US;
      2'h2: pb_cyc = PB_C2_US * CYC_PER_US;
      2'h3: pb_cyc = PB_C3_US * CYC_PER_US;
      default: pb_cyc = PB_C0_US * CYC_PER_US;
    endcase
    case (o_timeout_cfg.polling_timeout)
      2'h1: pt_cyc = P_POLL_US * CYC_PER_US * 2;
      2'h2: pt_cyc = P_POLL_US * CYC_PER_US / 2;
      2'h3: pt_cyc = P_POLL_US * CYC_PER_US * 4;
      default: pt_cyc = P_POLL_US * CYC_PER_US;
    endcase
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);
  a_init_blank: assert property (st_r == ST_INIT && o_state inside {ST_NORMAL, ST_FAULT}
    |-> cnt_r + 10 >= pb_cyc) else $error("init left before blanking");
  a_sleep_poll: assert property (st_r == ST_SLEEP && o_state == ST_POLL
    |-> cnt_r + 10 >= pt_cyc && cnt_r <= pt_cyc + 10) else $error("sleep length wrong");
  a_poll_sleep: assert property (st_r == ST_POLL && o_state == ST_SLEEP
    |-> cnt_r + 10 >= pb_cyc) else $error("poll left early");
  a_off_nvm: assert property (st_r == ST_OFF && o_state != ST_OFF
    |-> o_state == ST_NVM_LOAD) else $error("off left wrongly");
  a_wake_entry: assert property (st_r != ST_WAKE && o_state == ST_WAKE
    |-> o_wake_pin && o_status.wakeup_event_flag) else $error("wake entry without pin");
  a_spi_normal: assert property ($rose(o_spi_enable)
    |-> o_state == ST_NORMAL) else $error("commands on outside normal");
  a_cfg_write: assert property (i_cfg_wr && o_spi_enable && o_state == ST_NORMAL
    |-> ##[1:2] o_timeout_cfg == {$past(i_cfg_wdata.polling_timeout), $past(i_cfg_wdata.blanking_timeout)})
    else $error("config write lost");
  a_supply_fault: assert property (o_state == ST_NORMAL && i_int_supply_fault
    |-> ##[1:3] o_state == ST_FAULT) else $error("supply fault ignored");
  a_fault_vref: assert property (o_state == ST_FAULT |-> o_vref_en) else $error("reference off in fault");
  a_por_off: assert property (!i_por_ok [*6] |-> o_state == ST_OFF) else $error("not off without battery");
  a_held_dflt: assert property ((o_state == ST_RST_HELD) [*2]
    |-> o_timeout_cfg == 4'h0) else $error("held reset kept codes");
  c_sleep_poll: cover property (st_r == ST_SLEEP && o_state == ST_POLL);
  c_poll_wake: cover property (st_r == ST_POLL && o_state == ST_WAKE);
  c_norm_fault: cover property (st_r == ST_NORMAL && o_state == ST_FAULT);
endmodule
bind omf_mode_fsm omf_mode_fsm_monitor #(.P_POLL_US(P_POLL_US)) i_mon (
  .i_sys_clk, .i_resetn, .i_por_ok, .i_int_supply_fault, .i_cfg_wr, .i_cfg_wdata,
  .o_state, .o_wake_pin, .o_status, .o_timeout_cfg, .o_spi_enable, .o_vref_en
);

/* test/omf_mode_fsm_tb.sv */
// Self-checking bench of the operating-mode sequencer
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module omf_mode_fsm_tb;
  import omf_pkg::*;
  localparam int POLL_US = 20;
  localparam int POLL = POLL_US * CYC_PER_US;
  localparam int BLANK = PB_C0_US * CYC_PER_US;
  localparam int PB1 = PB_C1_US * CYC_PER_US;
  logic             i_sys_clk, i_resetn, i_por_ok, i_rst_pin, i_ctrl_cfg_pin, i_nvm_ready, i_nvm_data_bad;
  logic             i_calib_bad, i_diag_ok, i_int_supply_fault, i_overtemp, i_ot_mask, i_cfg_wr, i_status_rd;
  logic [WK_N-1:0]  i_wake_src;
  omf_cfg_wr_t      i_cfg_wdata;
  omf_state_t       o_state;
  omf_status_t      o_status;
  omf_timeout_cfg_t o_timeout_cfg;
  logic             o_wake_pin, o_spi_enable, o_vref_en, o_lp_osc_sel, o_chip_addr;
  int               errors, tests_run, n;
  omf_mode_fsm #(.P_POLL_US(POLL_US), .P_NVM_US(10)) i_dut (
    .i_sys_clk, .i_resetn, .i_por_ok, .i_rst_pin, .i_ctrl_cfg_pin, .i_wake_src, .i_nvm_ready,
    .i_nvm_data_bad, .i_calib_bad, .i_diag_ok, .i_int_supply_fault, .i_overtemp, .i_ot_mask,
    .i_cfg_wr, .i_cfg_wdata, .i_status_rd, .o_state, .o_wake_pin, .o_status, .o_timeout_cfg,
    .o_spi_enable, .o_vref_en, .o_lp_osc_sel, .o_chip_addr
  );
  omf_host_model i_host (.i_sys_clk, .o_rst_pin(i_rst_pin), .o_cfg_wr(i_cfg_wr), .o_cfg_wdata(i_cfg_wdata));
  initial
  begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  // Look just after the edge so the flops have settled
  task automatic cyc(input int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wait_st(input omf_state_t s, input int lim);
    n = 0;
    while (o_state !== s && n < lim)
    begin
      cyc(1);
      n++;
    end
    `CHK("state", s, o_state)
  endtask
  task automatic t_power(input logic bad);
    @(posedge i_sys_clk);
    i_nvm_data_bad <= bad;
    i_calib_bad <= bad;
    i_por_ok <= 1'b1;
    wait_st(ST_NVM_LOAD, 10);
    wait_st(ST_WAKE, 300);
    `CHK("load time", bad, n >= 10 * CYC_PER_US - 10)
    `CHK("flags", {1'h1, bad, bad, 2'h0}, o_status)
  endtask
  task automatic t_init(input logic pin, input omf_state_t exp);
    @(posedge i_sys_clk);
    i_ctrl_cfg_pin <= pin;
    cyc(5);
    i_host.set_rst(1'b1, 0);
    wait_st(ST_INIT, 30);
    `CHK("chip addr", pin, o_chip_addr)
    `CHK("spi in init", 1'b0, o_spi_enable)
    wait_st(exp, 1700);
    `CHK("blank len", 1'b1, n >= BLANK - 10 && n <= BLANK + 10)
  endtask
  task automatic t_faults();
    `CHK("spi on", 1'b1, o_spi_enable)
    i_host.cfg_write(4'h0, 2'h2, 2'h1);
    cyc(1);
    `CHK("cfg write", 4'h9, o_timeout_cfg)
    @(posedge i_sys_clk);
    i_ot_mask <= 1'b1;
    i_overtemp <= 1'b1;
    cyc(20);
    `CHK("masked ot", ST_NORMAL, o_state)
    `CHK("ot flag", 1'b1, o_status.overtemp_flag)
    @(posedge i_sys_clk);
    i_ot_mask <= 1'b0;
    wait_st(ST_FAULT, 10);
    `CHK("vref", 1'b1, o_vref_en)
    `CHK("spi in fault", 1'b1, o_spi_enable)
    @(posedge i_sys_clk);
    i_overtemp <= 1'b0;
    wait_st(ST_NORMAL, 20);
    @(posedge i_sys_clk);
    i_int_supply_fault <= 1'b1;
    wait_st(ST_FAULT, 10);
    @(posedge i_sys_clk);
    i_int_supply_fault <= 1'b0;
    wait_st(ST_NORMAL, 20);
  endtask
  task automatic t_held();
    i_host.set_rst(1'b0, 5);
    i_host.set_rst(1'b1, 0);
    cyc(30);
    `CHK("short low", ST_NORMAL, o_state)
    i_host.set_rst(1'b0, 0);
    wait_st(ST_RST_HELD, 30);
    `CHK("filter len", 1'b1, n >= RST_FLT_NRM_CYC)
    `CHK("cfg dropped", 4'h0, o_timeout_cfg)
    @(posedge i_sys_clk);
    i_diag_ok <= 1'b0;
    t_init(1'b0, ST_FAULT);
    @(posedge i_sys_clk);
    i_diag_ok <= 1'b1;
    wait_st(ST_NORMAL, 1700);
  endtask
  task automatic t_sleep();
    i_host.enter_sleep(2'h0, 2'h1);
    wait_st(ST_SLEEP, 40);
    `CHK("cfg kept", 4'h1, o_timeout_cfg)
    `CHK("lp osc", 1'b1, o_lp_osc_sel)
    wait_st(ST_POLL, 300);
    `CHK("poll period", 1'b1, n >= POLL - 10 && n <= POLL + 10)
    wait_st(ST_SLEEP, 300);
    `CHK("poll blank", 1'b1, n >= PB1 - 10)
    i_host.set_rst(1'b1, 50);
    i_host.set_rst(1'b0, 0);
    cyc(300);
    `CHK("sleep glitch", 1'b1, o_state inside {ST_SLEEP, ST_POLL})
    @(posedge i_sys_clk);
    i_wake_src <= 3'h1;
    wait_st(ST_WAKE, 1500);
    `CHK("wake delay", 1'b1, n >= PB1 + POLL - 10)
    `CHK("wake pin", 1'b1, o_wake_pin)
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #4000000;
    errors++;
    finish_test();
  end
  initial
  begin
    errors = 0;
    tests_run = 0;
    {i_resetn, i_por_ok, i_ctrl_cfg_pin, i_nvm_data_bad, i_calib_bad, i_status_rd} = 6'h00;
    {i_int_supply_fault, i_overtemp, i_ot_mask, i_wake_src} = 6'h00;
    {i_nvm_ready, i_diag_ok} = 2'h3;
    repeat (8) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    cyc(2);
    t_power(1'b1);
    @(posedge i_sys_clk);
    i_status_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_status_rd <= 1'b0;
    cyc(2);
    `CHK("pin after read", 1'b0, o_wake_pin)
    @(posedge i_sys_clk);
    i_por_ok <= 1'b0;
    wait_st(ST_OFF, 10);
    t_power(1'b0);
    i_host.cfg_write(4'h0, 2'h1, 2'h1);
    cyc(1);
    `CHK("cfg refused", 4'h0, o_timeout_cfg)
    t_init(1'b1, ST_NORMAL);
    t_faults();
    t_held();
    t_sleep();
    @(posedge i_sys_clk);
    i_por_ok <= 1'b0;
    wait_st(ST_OFF, 10);
    `CHK("off cfg", 4'h0, o_timeout_cfg)
    `CHK("off flags", 5'h00, o_status)
    finish_test();
  end
endmodule
